// ==== uart_dma_ring_buffer_port.sv ====
// serial port with receive ring fed by dma and self-stopping transmit ring
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module rx_stage_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 4) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  always_comb begin
    push = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_reg != '0);
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + {AW'(0), push} - {AW'(0), pop};
    in_ready_o = cnt_reg != (AW+1)'(DEPTH);
    out_valid_o = cnt_reg != '0;
    out_data_o = mem[rp_reg];
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end
endmodule

module uart_dma_ring_buffer_port import uart_ring_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic rx_line_i,
  output logic tx_line_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] in_mem [RING_DEPTH];
  logic [7:0] out_mem [RING_DEPTH];
  logic [4:0] pre_reg, pre_next;
  logic base_tick;
  logic rx_on_reg, rx_on_next, tx_go_reg, tx_go_next;
  logic [3:0] rx_baud_reg, rx_baud_next, tx_baud_reg, tx_baud_next;
  line_cfg_type cfg_reg, cfg_next;
  logic [SIZE_W-1:0] rx_size_reg, rx_size_next, tx_size_reg, tx_size_next;
  bus_phase_type ap_reg, ap_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic queue_ok_reg, queue_ok_next;
  logic [PTR_W-1:0] in_head_reg, in_head_next, in_tail_reg, in_tail_next;
  logic [PTR_W-1:0] out_head_reg, out_head_next, out_tail_reg, out_tail_next;
  logic [PTR_W-1:0] rx_count;
  logic ap_take, rd_pop, dp_wr, wr_ctrl, wr_tx, wr_rxsize, wr_txsize;
  logic tx_full, tx_empty, tx_busy, tx_load, tx_stop_svc, store;
  logic f_in_ready, f_valid, rx_push;
  logic [7:0] f_data, rx_byte;
  line_state_type rx_state_reg, rx_state_next, tx_state_reg, tx_state_next;
  logic [12:0] rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
  logic [12:0] rx_div, tx_div;
  logic [3:0] rx_bits_reg, rx_bits_next, tx_bits_reg, tx_bits_next;
  logic [8:0] rx_shift_reg, rx_shift_next;
  logic [11:0] tx_shift_reg, tx_shift_next;
  logic tx_line_reg, tx_line_next;

  // prescaler: one base tick per 32 system clocks
  always_comb begin
    base_tick = pre_reg == BASE_LAST;
    pre_next = base_tick ? 5'h00 : pre_reg + 5'h01;
  end
  always_ff @(posedge sys_clk_i) begin
    pre_reg <= !rst_b_i ? 5'h00 : pre_next;
  end

  // bus decode; hreadyout is low in reset and high after it, so every data phase is one cycle
  always_comb begin
    ap_take = hsel_i && hready_i && htrans_i[1];
    rx_count = ring_dist(in_head_reg, in_tail_reg, rx_size_reg);
    rd_pop = ap_take && !hwrite_i && haddr_i[7:0] == OFF_RXDATA
             && rx_count != '0;
    dp_wr = ap_reg.valid && ap_reg.write;
    wr_ctrl = dp_wr && ap_reg.addr == OFF_CTRL;
    wr_tx = dp_wr && ap_reg.addr == OFF_TXDATA;
    wr_rxsize = dp_wr && ap_reg.addr == OFF_RXSIZE && hwdata_i[6:0] >= SIZE_MIN
                && hwdata_i[6:0] <= SIZE_RESET && hwdata_i[31:7] == '0;
    wr_txsize = dp_wr && ap_reg.addr == OFF_TXSIZE && hwdata_i[6:0] >= SIZE_MIN
                && hwdata_i[6:0] <= SIZE_RESET && hwdata_i[31:7] == '0;
    tx_empty = out_head_reg == out_tail_reg;
    tx_full = ring_next(out_head_reg, tx_size_reg) == out_tail_reg;
    tx_busy = tx_state_reg != ST_IDLE || !tx_empty;
  end

  // control registers and read data
  always_comb begin
    ap_next = '{ap_take, hwrite_i, haddr_i[7:0]};
    rx_on_next = rx_on_reg;
    tx_go_next = tx_go_reg && !tx_stop_svc;
    rx_baud_next = rx_baud_reg;
    tx_baud_next = tx_baud_reg;
    cfg_next = cfg_reg;
    rx_size_next = wr_rxsize ? hwdata_i[6:0] : rx_size_reg;
    tx_size_next = wr_txsize ? hwdata_i[6:0] : tx_size_reg;
    queue_ok_next = wr_tx ? !tx_full : queue_ok_reg;
    if (wr_ctrl) begin
      rx_on_next = hwdata_i[CTRL_RX_ON];
      // software enabling wins over the service disabling in the same cycle
      tx_go_next = hwdata_i[CTRL_TX_GO] || (tx_go_reg && !tx_stop_svc);
      rx_baud_next = hwdata_i[CTRL_RX_BAUD+:4];
      tx_baud_next = hwdata_i[CTRL_TX_BAUD+:4];
      cfg_next = hwdata_i[CTRL_FMT+:5];
    end
    hrdata_next = 32'h0000_0000;
    if (ap_take && !hwrite_i) begin
      case (haddr_i[7:0])
        OFF_CTRL: hrdata_next = {15'h0000, cfg_reg, tx_baud_reg, rx_baud_reg,
                                 2'h0, tx_go_reg, rx_on_reg};
        OFF_STATUS: hrdata_next = {15'h0000, queue_ok_reg, 6'h00, tx_go_reg,
                                   tx_busy, 2'h0, rx_count};
        OFF_RXDATA: hrdata_next = rd_pop ? {24'h0, in_mem[in_tail_reg]} : '0;
        OFF_RXSIZE: hrdata_next = {25'h0, rx_size_reg};
        OFF_TXSIZE: hrdata_next = {25'h0, tx_size_reg};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ap_reg <= '0;
      rx_on_reg <= 1'b0;
      tx_go_reg <= 1'b0;
      rx_baud_reg <= BAUD_DEFAULT;
      tx_baud_reg <= BAUD_DEFAULT;
      cfg_reg <= LINE_DEFAULT;
      rx_size_reg <= SIZE_RESET;
      tx_size_reg <= SIZE_RESET;
      queue_ok_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      ap_reg <= ap_next;
      rx_on_reg <= rx_on_next;
      tx_go_reg <= tx_go_next;
      rx_baud_reg <= rx_baud_next;
      tx_baud_reg <= tx_baud_next;
      cfg_reg <= cfg_next;
      rx_size_reg <= rx_size_next;
      tx_size_reg <= tx_size_next;
      queue_ok_reg <= queue_ok_next;
      hrdata_reg <= hrdata_next;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
  assign hrdata_o = hrdata_reg;

  // ring pointers; the dma writer stalls for one cycle when a read pops
  always_comb begin
    store = f_valid && !rd_pop;
    in_head_next = store ? ring_next(in_head_reg, rx_size_reg) : in_head_reg;
    in_tail_next = in_tail_reg;
    if (rd_pop) begin
      in_tail_next = ring_next(in_tail_reg, rx_size_reg);
    end else if (store && in_head_next == in_tail_reg) begin
      in_tail_next = ring_next(in_tail_reg, rx_size_reg);
    end
    if (wr_ctrl && hwdata_i[CTRL_FLUSH]) begin
      in_tail_next = in_head_next;
    end
    if (wr_rxsize) begin
      in_head_next = '0;
      in_tail_next = '0;
    end
    out_head_next = (wr_tx && !tx_full) ?
                    ring_next(out_head_reg, tx_size_reg) : out_head_reg;
    out_tail_next = tx_load ? ring_next(out_tail_reg, tx_size_reg)
                            : out_tail_reg;
    if (wr_txsize) begin
      out_head_next = '0;
      out_tail_next = '0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      in_head_reg <= '0;
      in_tail_reg <= '0;
      out_head_reg <= '0;
      out_tail_reg <= '0;
    end else begin
      in_head_reg <= in_head_next;
      in_tail_reg <= in_tail_next;
      out_head_reg <= out_head_next;
      out_tail_reg <= out_tail_next;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (store) begin
      in_mem[in_head_reg] <= f_data;
    end
    if (wr_tx && !tx_full) begin
      out_mem[out_head_reg] <= hwdata_i[7:0];
    end
  end

  // receiver: finds the start edge on a base tick, samples mid-bit
  always_comb begin
    rx_div = baud_divisor(rx_baud_reg);
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bits_next = rx_bits_reg;
    rx_shift_next = rx_shift_reg;
    rx_push = 1'b0;
    // a parity bit lands above the data bits and is cut off by the mask, or by the 8-bit cast when there are eight data bits
    rx_byte = 8'((rx_shift_reg >> (4'h9 - rx_bits_reg)))
              & data_mask(cfg_reg.data_len);
    case (rx_state_reg)
      ST_IDLE: begin
        if (base_tick && !rx_line_i) begin
          rx_state_next = ST_START;
          // the zero count is seen one tick late, so aim one tick short
          rx_cnt_next = (rx_div - 13'h0001) >> 1;
        end
      end
      ST_START: begin
        if (base_tick && rx_cnt_reg == '0) begin
          rx_state_next = rx_line_i ? ST_IDLE : ST_DATA;
          rx_cnt_next = rx_div - 13'h0001;
          rx_bits_next = 4'h0;
        end else if (base_tick) begin
          rx_cnt_next = rx_cnt_reg - 13'h0001;
        end
      end
      ST_DATA: begin
        if (base_tick && rx_cnt_reg == '0) begin
          rx_shift_next = {rx_line_i, rx_shift_reg[8:1]};
          rx_bits_next = rx_bits_reg + 4'h1;
          rx_cnt_next = rx_div - 13'h0001;
          if (rx_bits_reg == {2'h0, cfg_reg.data_len} + 4'h4
              + {3'h0, cfg_reg.parity != PAR_NONE}) begin
            rx_state_next = ST_STOP;
          end
        end else if (base_tick) begin
          rx_cnt_next = rx_cnt_reg - 13'h0001;
        end
      end
      ST_STOP: begin
        if (base_tick && rx_cnt_reg == '0) begin
          // parity and framing faults are not reported, the byte is kept
          rx_push = 1'b1;
          rx_state_next = ST_IDLE;
        end else if (base_tick) begin
          rx_cnt_next = rx_cnt_reg - 13'h0001;
        end
      end
      default: rx_state_next = ST_IDLE;
    endcase
    if (!rx_on_reg) begin
      rx_state_next = ST_IDLE;
      rx_push = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rx_state_reg <= ST_IDLE;
      rx_cnt_reg <= '0;
      rx_bits_reg <= '0;
      rx_shift_reg <= '0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bits_reg <= rx_bits_next;
      rx_shift_reg <= rx_shift_next;
    end
  end

  // a full staging fifo drops the character rather than stall the line
  rx_stage_fifo #(.WIDTH(8), .DEPTH(RX_FIFO_DEPTH)) u_stage (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(rx_push),
    .in_ready_o(f_in_ready),
    .in_data_i(rx_byte),
    .out_valid_o(f_valid),
    .out_ready_i(!rd_pop),
    .out_data_o(f_data)
  );

  // transmitter: drains the output ring while enabled, then disables itself
  always_comb begin
    tx_div = baud_divisor(tx_baud_reg);
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bits_next = tx_bits_reg;
    tx_shift_next = tx_shift_reg;
    tx_load = 1'b0;
    tx_stop_svc = 1'b0;
    case (tx_state_reg)
      ST_IDLE: begin
        // loading on a base tick gives the start bit a full bit time
        if (tx_go_reg && !tx_empty && base_tick) begin
          tx_load = 1'b1;
          tx_state_next = ST_DATA;
          tx_cnt_next = tx_div - 13'h0001;
          tx_bits_next = 4'h7 + {2'h0, cfg_reg.data_len}
                         + {3'h0, cfg_reg.parity != PAR_NONE}
                         + {3'h0, cfg_reg.two_stop};
          tx_shift_next = (12'hFFF << (4'h6 + {2'h0, cfg_reg.data_len}
                           + {3'h0, cfg_reg.parity != PAR_NONE}))
                          | {3'h0, out_mem[out_tail_reg]
                             & data_mask(cfg_reg.data_len), 1'b0};
          if (cfg_reg.parity != PAR_NONE) begin
            tx_shift_next[4'h6 + {2'h0, cfg_reg.data_len}] =
              ^(out_mem[out_tail_reg] & data_mask(cfg_reg.data_len))
              ^ (cfg_reg.parity == PAR_ODD);
          end
        end else if (tx_go_reg && tx_empty) begin
          tx_stop_svc = 1'b1;
        end
      end
      ST_DATA: begin
        if (base_tick && tx_cnt_reg == '0) begin
          tx_shift_next = {1'b1, tx_shift_reg[11:1]};
          tx_bits_next = tx_bits_reg - 4'h1;
          tx_cnt_next = tx_div - 13'h0001;
          if (tx_bits_reg == 4'h1) begin
            tx_state_next = ST_IDLE;
          end
        end else if (base_tick) begin
          tx_cnt_next = tx_cnt_reg - 13'h0001;
        end
      end
      default: tx_state_next = ST_IDLE;
    endcase
    tx_line_next = (tx_state_next == ST_DATA) ? tx_shift_next[0] : 1'b1;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      tx_state_reg <= ST_IDLE;
      tx_cnt_reg <= '0;
      tx_bits_reg <= '0;
      tx_shift_reg <= 12'hFFF;
      tx_line_reg <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bits_reg <= tx_bits_next;
      tx_shift_reg <= tx_shift_next;
      tx_line_reg <= tx_line_next;
    end
  end
  assign tx_line_o = tx_line_reg;

  sequence s_tick_gap;
    !base_tick [*8];
  endsequence
  AST_BASE_GAP: assert property (base_tick |=> s_tick_gap)
    else $error("base tick repeated too soon");
  AST_DEFAULT_FMT: assert property (
      $rose(rst_b_i) |-> cfg_reg == LINE_DEFAULT)
    else $error("line format not 8N1 after reset");
  AST_STORE_HEAD: assert property (store && !wr_rxsize |=>
      in_head_reg == ring_next($past(in_head_reg), rx_size_reg))
    else $error("stored byte did not advance head");
  AST_OVERWRITE: assert property (store && !wr_ctrl && !wr_rxsize &&
      ring_next(in_head_reg, rx_size_reg) == in_tail_reg |=>
      in_tail_reg == ring_next($past(in_tail_reg), rx_size_reg))
    else $error("full ring did not drop oldest byte");
  AST_POP_TAIL: assert property (rd_pop && !wr_ctrl && !wr_rxsize |=>
      in_tail_reg == ring_next($past(in_tail_reg), rx_size_reg)
      && hrdata_reg[7:0] == in_mem[$past(in_tail_reg)])
    else $error("read did not advance tail");
  AST_EMPTY_ZERO: assert property (in_head_reg == in_tail_reg |->
      rx_count == '0 && !rd_pop)
    else $error("empty ring reported data");
  AST_WRAP: assert property ({1'b0, in_head_reg} < rx_size_reg &&
      {1'b0, out_tail_reg} < tx_size_reg)
    else $error("pointer beyond ring length");
  AST_TX_STOP: assert property (
      tx_state_reg == ST_IDLE && tx_go_reg && tx_empty && !wr_ctrl
      |=> !tx_go_reg)
    else $error("transmit service not disabled on empty ring");
  AST_TX_START: assert property (
      tx_load |=> tx_state_reg == ST_DATA ##1 !tx_line_reg [*1])
    else $error("queued byte did not start");
  AST_QUEUE_FULL: assert property (
      wr_tx && tx_full |=> !queue_ok_reg
      && out_head_reg == $past(out_head_reg))
    else $error("full ring accepted a byte");
  AST_NOT_BUSY: assert property (!tx_busy |-> tx_line_reg)
    else $error("line not idle while not busy");
  AST_CLOSED: assert property (!rx_on_reg |=> rx_state_reg == ST_IDLE)
    else $error("receiver ran while closed");
endmodule
`default_nettype wire

// ==== uart_ring_pkg.sv ====
// constants, types and helpers shared by the serial ring-buffer port
package uart_ring_pkg;
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int BASE_PRESCALE = 2 * 16;
  localparam logic [4:0] BASE_LAST = 5'(BASE_PRESCALE - 1);
  localparam int RING_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int SIZE_W = 7;
  localparam logic [SIZE_W-1:0] SIZE_RESET = 7'h40;
  localparam logic [SIZE_W-1:0] SIZE_MIN = 7'h02;
  localparam int RX_FIFO_DEPTH = 4;
  localparam logic [3:0] BAUD_DEFAULT = 4'h9;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RXDATA = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0C;
  localparam logic [7:0] OFF_RXSIZE = 8'h10;
  localparam logic [7:0] OFF_TXSIZE = 8'h14;
  localparam int CTRL_RX_ON = 0;
  localparam int CTRL_TX_GO = 1;
  localparam int CTRL_FLUSH = 2;
  localparam int CTRL_RX_BAUD = 4;
  localparam int CTRL_TX_BAUD = 8;
  localparam int CTRL_FMT = 12;
  localparam int STAT_TX_BUSY = 8;
  localparam int STAT_TX_GO = 9;
  localparam int STAT_QUEUE_OK = 16;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  typedef struct packed {
    logic [1:0] parity;
    logic two_stop;
    logic [1:0] data_len;
  } line_cfg_type;
  localparam line_cfg_type LINE_DEFAULT = '{2'h0, 1'b0, 2'h3};
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_phase_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_START = 2'b01, ST_DATA = 2'b11, ST_STOP = 2'b10
  } line_state_type;
  function automatic logic [12:0] baud_divisor(input logic [3:0] sel);
    case (sel)
      4'h1: baud_divisor = 13'h1ADB;
      4'h2: baud_divisor = 13'h0D6E;
      4'h3: baud_divisor = 13'h06B7;
      4'h4: baud_divisor = 13'h035B;
      4'h5: baud_divisor = 13'h01AE;
      4'h6: baud_divisor = 13'h00D7;
      4'h7: baud_divisor = 13'h006B;
      4'h8: baud_divisor = 13'h0048;
      4'hA: baud_divisor = 13'h001B;
      4'hB: baud_divisor = 13'h0012;
      4'hC: baud_divisor = 13'h0009;
      4'hD: baud_divisor = 13'h0004;
      4'hE: baud_divisor = 13'h0002;
      4'hF: baud_divisor = 13'h0001;
      default: baud_divisor = 13'h0036;
    endcase
  endfunction
  function automatic logic [PTR_W-1:0] ring_next(input logic [PTR_W-1:0] p,
                                                  input logic [SIZE_W-1:0] s);
    ring_next = ({1'b0, p} + 7'h01 >= s) ? '0 : p + 6'h01;
  endfunction
  function automatic logic [PTR_W-1:0] ring_dist(input logic [PTR_W-1:0] h,
      input logic [PTR_W-1:0] t, input logic [SIZE_W-1:0] s);
    logic [SIZE_W-1:0] d;
    d = (h >= t) ? {1'b0, h} - {1'b0, t} : {1'b0, h} + s - {1'b0, t};
    ring_dist = d[PTR_W-1:0];
  endfunction
  function automatic logic [7:0] data_mask(input logic [1:0] dl);
    data_mask = 8'hFF >> (2'h3 - dl);
  endfunction
endpackage

// ==== serial_peer_model.sv ====
// serial device model standing on the far side of the port's line pins
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model #(parameter int TX_BIT = 32) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic [7:0] got[$];
  logic [7:0] sh;
  // line idles high between frames; no handshake pins, sender never paused
  initial line_o = 1'b1;
  task automatic send(input logic [7:0] b, input int bit_clks);
    line_o <= 1'b0;
    repeat (bit_clks) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (bit_clks) @(posedge clk_i);
  endtask
  // sample mid-bit, lsb first; returns to hunting inside the stop bit
  always begin
    @(negedge line_i);
    repeat (TX_BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (TX_BIT) @(posedge clk_i);
      sh[i] = line_i;
    end
    repeat (TX_BIT) @(posedge clk_i);
    got.push_back(sh);
  end
endmodule
`default_nettype wire

// ==== uart_dma_ring_buffer_port_tb.sv ====
// self-checking bench for the serial ring-buffer port
`timescale 1ns/1ns
`default_nettype none
module uart_dma_ring_buffer_port_tb;
  import uart_ring_pkg::*;
  localparam int RX_BIT = 64;
  localparam int TX_BIT = 32;
  localparam int LIMIT = 40000;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, rx_line, tx_line;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 14;
  int cyc = 0;
  int cap = 63;
  logic [31:0] rd;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  logic [7:0] tx_q[$];
  always #50 sys_clk_i = ~sys_clk_i;
  uart_dma_ring_buffer_port dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .rx_line_i(rx_line), .tx_line_o(tx_line));
  serial_peer_model #(.TX_BIT(TX_BIT)) peer (.clk_i(sys_clk_i),
    .line_i(tx_line), .line_o(rx_line));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // single word transfer; address phase held until hready seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] ctrl_val(input logic on,
      input logic [3:0] rb, input logic [3:0] tb, input line_cfg_type f);
    ctrl_val = 32'h0;
    ctrl_val[CTRL_RX_ON] = on;
    ctrl_val[CTRL_RX_BAUD +: 4] = rb;
    ctrl_val[CTRL_TX_BAUD +: 4] = tb;
    ctrl_val[CTRL_FMT +: 5] = f;
  endfunction
  // the model of the ring: once capacity is passed the oldest byte goes
  task automatic rx_frames(input int n);
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      peer.send(b, RX_BIT);
      exp_q.push_back(b);
      if (exp_q.size() > cap) exp_q.pop_front();
    end
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic drain();
    bus(1'b0, OFF_STATUS, 32'h0);
    check({26'h0, rd[5:0]}, 32'(exp_q.size()));
    while (exp_q.size() > 0) begin
      bus(1'b0, OFF_RXDATA, 32'h0);
      check(rd, {24'h0, exp_q.pop_front()});
    end
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc > LIMIT) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    @(posedge sys_clk_i);
    bus(1'b0, OFF_CTRL, 32'h0);
    check(rd, ctrl_val(1'b0, BAUD_DEFAULT, BAUD_DEFAULT, LINE_DEFAULT));
    bus(1'b0, OFF_RXSIZE, 32'h0);
    check(rd, {25'h0, SIZE_RESET});
    bus(1'b0, 8'h40, 32'hFFFFFFFF);
    check(rd, 32'h0);
    bus(1'b0, OFF_RXDATA, 32'h0);
    check(rd, 32'h0);
    $display("test reset values done");
    bus(1'b1, OFF_CTRL, ctrl_val(1'b0, 4'hE, 4'hF, '{PAR_ODD, 1'b1, 2'h2}));
    bus(1'b0, OFF_CTRL, 32'h0);
    check(rd, ctrl_val(1'b0, 4'hE, 4'hF, '{PAR_ODD, 1'b1, 2'h2}));
    // receive slower than transmit, back to the default format
    bus(1'b1, OFF_CTRL, ctrl_val(1'b1, 4'hE, 4'hF, LINE_DEFAULT));
    rx_frames(3);
    drain();
    $display("test receive order done");
    bus(1'b1, OFF_RXSIZE, 32'h4);
    cap = 3;
    rx_frames(5);
    drain();
    $display("test ring overwrite done");
    bus(1'b1, OFF_TXSIZE, 32'h4);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      bus(1'b1, OFF_TXDATA, {24'h0, b});
      bus(1'b0, OFF_STATUS, 32'h0);
      check({31'h0, rd[STAT_QUEUE_OK]}, (i < 3) ? 32'h1 : 32'h0);
      if (i < 3) tx_q.push_back(b);
    end
    // queued bytes must wait for the enable
    repeat (400) @(posedge sys_clk_i);
    check(32'(peer.got.size()), 32'h0);
    bus(1'b1, OFF_CTRL, ctrl_val(1'b1, 4'hE, 4'hF, LINE_DEFAULT) | 32'h2);
    fork
      rx_frames(1);
      while (peer.got.size() < 3) @(posedge sys_clk_i);
    join
    repeat (40) @(posedge sys_clk_i);
    for (int i = 0; i < 3; i++) begin
      check({24'h0, peer.got.pop_front()}, {24'h0, tx_q.pop_front()});
    end
    check(32'(peer.got.size()), 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0);
    check({30'h0, rd[STAT_TX_GO], rd[STAT_TX_BUSY]}, 32'h0);
    drain();
    $display("test duplex transmit done");
    rx_frames(1);
    exp_q.delete();
    bus(1'b0, OFF_STATUS, 32'h0);
    check({26'h0, rd[5:0]}, 32'h1);
    // flush: tail jumps to head, the waiting byte is dropped
    bus(1'b1, OFF_CTRL, ctrl_val(1'b1, 4'hE, 4'hF, LINE_DEFAULT) | 32'h4);
    bus(1'b0, OFF_STATUS, 32'h0);
    check({26'h0, rd[5:0]}, 32'h0);
    $display("test flush done");
    bus(1'b1, OFF_CTRL, ctrl_val(1'b0, 4'hE, 4'hF, LINE_DEFAULT));
    peer.send(8'hA5, RX_BIT);
    repeat (4) @(posedge sys_clk_i);
    bus(1'b0, OFF_STATUS, 32'h0);
    check({26'h0, rd[5:0]}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("test close done");
    complete_run();
  end
endmodule
`default_nettype wire
